//--- design/panel_meter.sv
// Purpose: sequencer, display and control lines of a 3.5-digit meter
// Assumes: integrator comparator and control lines are asynchronous pins
// Notes: registers over AXI4-Lite; all pin outputs come from flip-flops
`default_nettype none

module panel_meter
	import meter_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmp_in,
	input wire logic freeze_line_in,
	output logic done_line_o,
	output logic done_line_oe,
	input wire logic blank_line_in,
	output logic over_line_o,
	output logic over_line_oe,
	input wire logic check_n,
	input wire logic [2:0] dp_sel_n,
	output logic sw_input,
	output logic sw_ref,
	output logic ref_neg,
	output logic sw_zero,
	output logic [22:0] seg,
	output logic sign_bar,
	output logic sign_vert,
	output logic [2:0] dp,
	output reading_s reading,
	output logic irq
);
	logic [6:0] pin_raw, s1_q, s2_q, s3_q, filt_q;
	logic [31:0] tick_cnt_q;
	logic tick;
	logic [11:0] period_q, cnt_q;
	phase_e phase_q, phase_d;
	logic pol_cmp_q, crossed, at_max, cnt_clear, cnt_inc;
	logic [3:0] dig_inc;
	logic [2:0] dig_carry;
	logic [3:0] dig [3];
	logic half_q, ovr_q;
	logic sw_input_q, sw_ref_q, sw_zero_q;
	reading_s disp_q, result;
	logic conv_done, done_oe_q, over_oe_q, line_low_q;
	logic [HOLDOFF-1:0] done_hist_q, over_hist_q;
	logic freeze_act, off_act, check_act;
	logic [2:0] dp_lit;
	logic [22:0] seg_q;
	logic sign_bar_q, sign_vert_q;
	logic [2:0] dp_q;
	logic [1:0] ctrl_q, mask_q, status_q, status_set, status_clr;
	logic irq_q;
	logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q, rd_resp;
	logic arready_q, rvalid_q, wr_go;
	logic [31:0] rdata_q, rd_data;

	// seven-segment pattern, bit order gfedcba
	function automatic logic [6:0] seg7(input logic [3:0] d);
		case (d)
		4'h0: seg7 = 7'h3F;
		4'h1: seg7 = 7'h06;
		4'h2: seg7 = 7'h5B;
		4'h3: seg7 = 7'h4F;
		4'h4: seg7 = 7'h66;
		4'h5: seg7 = 7'h6D;
		4'h6: seg7 = 7'h7D;
		4'h7: seg7 = 7'h07;
		4'h8: seg7 = 7'h7F;
		4'h9: seg7 = 7'h6F;
		default: seg7 = 7'h00;
		endcase
	endfunction

	// three-stage synchronisers; a level counts once stages two and three agree
	assign pin_raw = {dp_sel_n, check_n, blank_line_in, freeze_line_in, cmp_in};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			s3_q <= SYNC_RST;
			filt_q <= SYNC_RST;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
		end
	end

	// count tick: one enable pulse per conversion count
	assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			tick_cnt_q <= 32'h0;
		end else begin
			tick_cnt_q <= 32'(tick_cnt_q + 32'h1);
		end
	end

	// free-running conversion period, no external trigger
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_q <= 12'h000;
		end else if (tick) begin
			period_q <= (period_q == CONV_LAST) ? 12'h000 : 12'(period_q + 12'h1);
		end
	end

	// phase sequencer
	assign crossed = (filt_q[SY_CMP] != pol_cmp_q);
	assign at_max = half_q && dig[2] == BCD_NINE && dig[1] == BCD_NINE &&
		dig[0] == BCD_NINE;
	always_comb begin
		phase_d = phase_q;
		if (tick) begin
			case (phase_q)
			PH_ZERO: if (period_q == CONV_LAST) phase_d = PH_INTEG;
			PH_INTEG: if (cnt_q == INT_LAST) phase_d = PH_POLAR;
			PH_POLAR: phase_d = PH_DEINT;
			PH_DEINT: if (crossed || at_max) phase_d = PH_SETTLE;
			PH_SETTLE: phase_d = PH_STORE;
			PH_STORE: phase_d = PH_ZERO;
			default: phase_d = PH_ZERO;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= PH_ZERO;
		end else begin
			phase_q <= phase_d;
		end
	end

	// integration length counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 12'h000;
		end else if (tick) begin
			cnt_q <= (phase_q == PH_INTEG) ? 12'(cnt_q + 12'h1) : 12'h000;
		end
	end

	// analog switch controls follow the next phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_input_q <= 1'b0;
			sw_ref_q <= 1'b0;
			sw_zero_q <= 1'b1;
		end else begin
			sw_input_q <= (phase_d == PH_INTEG);
			sw_ref_q <= (phase_d == PH_DEINT);
			sw_zero_q <= (phase_d == PH_ZERO) || (phase_d == PH_SETTLE);
		end
	end

	// polarity sampled at the end of integration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pol_cmp_q <= 1'b1;
		end else if (tick && phase_q == PH_POLAR) begin
			pol_cmp_q <= filt_q[SY_CMP];
		end
	end

	// de-integration counter in BCD, three decades and a half digit
	assign cnt_clear = tick && (phase_q == PH_POLAR);
	assign cnt_inc = tick && (phase_q == PH_DEINT) && !crossed && !at_max;
	assign dig_inc[0] = cnt_inc;
	for (genvar i = 0; i < 3; i++) begin : g_dec
		bcd_digit u_dig (
			.aclk(aclk),
			.aresetn(aresetn),
			.clear(cnt_clear),
			.inc(dig_inc[i]),
			.val(dig[i]),
			.carry(dig_carry[i])
		);
		assign dig_inc[i+1] = dig_carry[i];
	end

	// half digit and overrange flag
	always_ff @(posedge aclk) begin
		if (!aresetn || cnt_clear) begin
			half_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			if (dig_inc[3]) begin
				half_q <= 1'b1;
			end
			if (tick && phase_q == PH_DEINT && at_max && !crossed) begin
				ovr_q <= 1'b1;
			end
		end
	end

	// completed result and latch, held while frozen
	assign conv_done = tick && (phase_q == PH_STORE);
	assign result = '{over: ovr_q, neg: !pol_cmp_q, half: half_q,
		d2: dig[2], d1: dig[1], d0: dig[0]};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			disp_q <= READING_RST;
		end else if (conv_done && !freeze_act) begin
			disp_q <= result;
		end
	end

	// open-drain control lines and their own-drive holdoff
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_oe_q <= 1'b0;
			over_oe_q <= 1'b0;
			line_low_q <= 1'b0;
			done_hist_q <= '0;
			over_hist_q <= '0;
		end else begin
			if (tick) begin
				done_oe_q <= (phase_q == PH_STORE);
			end
			if (conv_done) begin
				over_oe_q <= ovr_q;
			end
			line_low_q <= 1'b0;
			done_hist_q <= {done_hist_q[HOLDOFF-2:0], done_oe_q};
			over_hist_q <= {over_hist_q[HOLDOFF-2:0], over_oe_q};
		end
	end

	// a line counts as pulled by the outside only while we release it
	assign freeze_act = (!filt_q[SY_FREEZE] && !done_oe_q && !(|done_hist_q)) ||
		ctrl_q[CTRL_FREEZE_BIT];
	assign off_act = (!filt_q[SY_BLANK] && !over_oe_q && !(|over_hist_q)) ||
		ctrl_q[CTRL_BLANK_BIT];
	assign check_act = !filt_q[SY_CHECK];
	assign dp_lit = ~filt_q[SY_DP+:3];

	// display drive: off, then test, then overrange, then data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_q <= SEG_NONE;
			sign_bar_q <= 1'b0;
			sign_vert_q <= 1'b0;
			dp_q <= 3'h0;
		end else if (off_act) begin
			seg_q <= SEG_NONE;
			sign_bar_q <= 1'b0;
			sign_vert_q <= 1'b0;
			dp_q <= 3'h0;
		end else if (check_act) begin
			seg_q <= SEG_ALL;
			sign_bar_q <= 1'b1;
			sign_vert_q <= 1'b1;
			dp_q <= dp_lit;
		end else begin
			sign_bar_q <= 1'b1;
			sign_vert_q <= !disp_q.neg;
			dp_q <= dp_lit;
			if (disp_q.over) begin
				seg_q <= SEG_NONE;
			end else begin
				seg_q <= {{2{disp_q.half}}, seg7(disp_q.d2), seg7(disp_q.d1),
					seg7(disp_q.d0)};
			end
		end
	end

	// sticky status, set wins over a write-one clear
	assign status_set = {conv_done && ovr_q, conv_done};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= STATUS_RST;
			irq_q <= 1'b0;
		end else begin
			status_q <= (status_q & ~status_clr) | status_set;
			irq_q <= |(status_q & mask_q);
		end
	end

	// write channel acceptance
	assign wr_go = aw_got_q && w_got_q && !bvalid_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			aw_addr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				awready_q <= 1'b0;
			end else if (wr_go) begin
				aw_got_q <= 1'b0;
			end else if (!aw_got_q && !bvalid_q) begin
				awready_q <= 1'b1;
			end
			if (s_axi_wvalid && wready_q) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				wready_q <= 1'b0;
			end else if (wr_go) begin
				w_got_q <= 1'b0;
			end else if (!w_got_q && !bvalid_q) begin
				wready_q <= 1'b1;
			end
		end
	end

	// register writes and write response
	assign status_clr = (wr_go && aw_addr_q == REG_STATUS && wstrb_q[0]) ?
		wdata_q[1:0] : 2'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			mask_q <= MASK_RST;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= RESP_OKAY;
			case (aw_addr_q)
			REG_CTRL: if (wstrb_q[0]) ctrl_q <= wdata_q[1:0];
			REG_MASK: if (wstrb_q[0]) mask_q <= wdata_q[1:0];
			REG_STATUS, REG_RESULT: ;
			default: bresp_q <= RESP_SLVERR;
			endcase
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read decode
	always_comb begin
		rd_data = 32'h0;
		rd_resp = RESP_OKAY;
		case (s_axi_araddr)
		REG_CTRL: rd_data = 32'(ctrl_q);
		REG_STATUS: rd_data = 32'(status_q);
		REG_MASK: rd_data = 32'(mask_q);
		REG_RESULT: rd_data = {10'h000, phase_q, 1'b0, disp_q};
		default: rd_resp = RESP_SLVERR;
		endcase
	end

	// read channel, answer one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_resp;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign done_line_o = line_low_q;
	assign done_line_oe = done_oe_q;
	assign over_line_o = line_low_q;
	assign over_line_oe = over_oe_q;
	assign sw_input = sw_input_q;
	assign sw_ref = sw_ref_q;
	assign ref_neg = pol_cmp_q;
	assign sw_zero = sw_zero_q;
	assign seg = seg_q;
	assign sign_bar = sign_bar_q;
	assign sign_vert = sign_vert_q;
	assign dp = dp_q;
	assign reading = disp_q;
	assign irq = irq_q;

	// helper counters for timing checks
	logic [31:0] integ_len_q, conv_len_q;
	logic seen_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			integ_len_q <= 32'h0;
			conv_len_q <= 32'h0;
			seen_q <= 1'b0;
		end else begin
			integ_len_q <= (phase_q == PH_INTEG) ? 32'(integ_len_q + 32'h1) : 32'h0;
			if (phase_q == PH_ZERO && phase_d == PH_INTEG) begin
				conv_len_q <= 32'h0;
				seen_q <= 1'b1;
			end else begin
				conv_len_q <= 32'(conv_len_q + 32'h1);
			end
		end
	end

	a_integ_length: assert property (@(posedge aclk) disable iff (!aresetn)
		(phase_q == PH_INTEG && phase_d != PH_INTEG) |->
		integ_len_q == 32'(INT_TICKS * TICK_CYCLES - 1))
		else $error("integration phase length wrong");
	a_conv_period: assert property (@(posedge aclk) disable iff (!aresetn)
		(phase_q == PH_ZERO && phase_d == PH_INTEG && seen_q) |->
		conv_len_q == 32'(CONV_TICKS * TICK_CYCLES - 1))
		else $error("conversion period wrong");
	a_phase_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
		$onehot(phase_q) and (conv_done |=> phase_q == PH_ZERO))
		else $error("phase sequence broken");
	a_ovr_blank: assert property (@(posedge aclk) disable iff (!aresetn)
		(!off_act && !check_act && disp_q.over) |=>
		(seg_q == SEG_NONE && sign_bar_q && dp_q == $past(dp_lit)))
		else $error("overrange display wrong");
	a_freeze_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		freeze_act |=> $stable(disp_q))
		else $error("reading changed while frozen");
	a_blank_all: assert property (@(posedge aclk) disable iff (!aresetn)
		off_act |=> (seg_q == SEG_NONE && !sign_bar_q && !sign_vert_q && dp_q == 3'h0))
		else $error("display not blanked");
	a_check_all: assert property (@(posedge aclk) disable iff (!aresetn)
		(!off_act && check_act) |=> (seg_q == SEG_ALL && sign_bar_q && sign_vert_q))
		else $error("segment test pattern wrong");
	a_sign_track: assert property (@(posedge aclk) disable iff (!aresetn)
		(conv_done && !freeze_act) |=> ##1 (!off_act && !check_act) |->
		(disp_q.neg == !pol_cmp_q) && (sign_vert_q == pol_cmp_q))
		else $error("polarity sign mismatch");
	a_bcd_range: assert property (@(posedge aclk) disable iff (!aresetn)
		disp_q.d2 <= BCD_NINE && disp_q.d1 <= BCD_NINE && disp_q.d0 <= BCD_NINE)
		else $error("display digit out of range");
	a_done_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done |=> done_oe_q ##1 done_oe_q)
		else $error("completion pulse missing");
	a_over_line: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done |=> (over_oe_q == $past(ovr_q)) && !over_line_o)
		else $error("over_limit line wrong");
endmodule

`default_nettype wire

//--- design/meter_pkg.sv
// Purpose: shared constants and types of the panel meter control block
// Assumes: 100 MHz aclk, synchronous active-low reset
// Notes: count rates derive from the integration time and counts per phase
//
// Contract
// - result above 1999 counts blanks all digits; sign and decimal point stay lit
// - freeze line low keeps the last completed reading on the display
// - display_off line low turns the whole display off
// - segment_check low lights all 23 segments, reading 1888 with sign
// - conversions self-start at 2.5 complete conversions per second
// - input integration lasts 100 ms for 50/60 Hz rejection
// - six-phase dual-slope sequence with auto-zero, one result per cycle
// - polarity detected each conversion and shown as plus or minus sign
// - result is signed, up to 1999 counts: sign, half digit, three digits
// - conversion_done falls when a conversion completes
// - over_limit low while the latest result exceeds 1999, high otherwise
// - freeze also holds the parallel BCD latch
// - freeze/done and display_off/over_limit each share one open-drain line
`default_nettype none

package meter_pkg;
	// timebase
	localparam int CLK_PERIOD_NS = 10;
	localparam int INT_TIME_MS = 100;
	localparam int INT_TICKS = 1000;
	localparam int COUNT_TIME_NS = INT_TIME_MS * 1000000 / INT_TICKS;
	localparam int TICK_CYCLES_DEF = COUNT_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_PERIOD_MS = 400;
	localparam int CONV_TICKS = CONV_PERIOD_MS * INT_TICKS / INT_TIME_MS;
	localparam logic [11:0] CONV_LAST = 12'(CONV_TICKS - 1);
	localparam logic [11:0] INT_LAST = 12'(INT_TICKS - 1);
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam int HOLDOFF = 4;

	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_RESULT = 8'h0C;
	localparam int CTRL_FREEZE_BIT = 0;
	localparam int CTRL_BLANK_BIT = 1;
	localparam int ST_DONE_BIT = 0;
	localparam int ST_OVER_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [1:0] STATUS_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// pin synchroniser layout: {dp_sel_n[2:0], check_n, blank, freeze, cmp}
	localparam int SY_CMP = 0;
	localparam int SY_FREEZE = 1;
	localparam int SY_BLANK = 2;
	localparam int SY_CHECK = 3;
	localparam int SY_DP = 4;
	localparam logic [6:0] SYNC_RST = 7'h7E;

	// display
	localparam logic [22:0] SEG_ALL = 23'h7FFFFF;
	localparam logic [22:0] SEG_NONE = 23'h000000;

	typedef enum logic [5:0] {
		PH_ZERO = 6'h01,
		PH_INTEG = 6'h02,
		PH_POLAR = 6'h04,
		PH_DEINT = 6'h08,
		PH_SETTLE = 6'h10,
		PH_STORE = 6'h20
	} phase_e;

	typedef struct packed {
		logic over;
		logic neg;
		logic half;
		logic [3:0] d2;
		logic [3:0] d1;
		logic [3:0] d0;
	} reading_s;

	localparam reading_s READING_RST = 15'h0000;
endpackage

`default_nettype wire

//--- design/bcd_digit.sv
// Purpose: one decade of the de-integration counter
// Assumes: clear and inc are one-cycle enables on aclk
// Notes: carry is combinational so decades ripple in one cycle
`default_nettype none

module bcd_digit
	import meter_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic inc,
	output logic [3:0] val,
	output logic carry
);
	logic [3:0] val_q;

	// decade counter, wraps from nine to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			val_q <= 4'h0;
		end else if (clear) begin
			val_q <= 4'h0;
		end else if (inc) begin
			val_q <= (val_q == BCD_NINE) ? 4'h0 : 4'(val_q + 4'h1);
		end
	end

	assign val = val_q;
	assign carry = inc && (val_q == BCD_NINE);
endmodule

`default_nettype wire

//--- sim/meter_far_side.sv
// Purpose: far side of the meter: integrator and control-line driver
// Assumes: one integrator step per aclk, reference step of 1000
// Notes: shared control lines are open drain with pull-ups
`default_nettype none

module meter_far_side (
	input wire logic aclk,
	input wire logic sw_input,
	input wire logic sw_ref,
	input wire logic ref_neg,
	input wire logic sw_zero,
	input wire logic signed [15:0] vin,
	input wire logic done_line_oe,
	input wire logic over_line_oe,
	input wire logic hold_req,
	input wire logic blank_req,
	output logic cmp_in,
	output logic freeze_wire,
	output logic blank_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic signed [31:0] acc_q;
	// ramp away from zero on the input, back toward zero on the reference
	always_ff @(posedge aclk) begin
		if (sw_zero)
			acc_q <= '0;
		else if (sw_input)
			acc_q <= acc_q + 32'(vin);
		else if (sw_ref)
			acc_q <= ref_neg ? acc_q - 32'sd1000 : acc_q + 32'sd1000;
	end
	assign cmp_in = acc_q > 0;
	// wired lines: low while either side pulls
	assign freeze_wire = ~(done_line_oe | hold_req);
	assign blank_wire = ~(over_line_oe | blank_req);
endmodule

`default_nettype wire

//--- sim/panel_meter_tb.sv
// Purpose: self-checking bench of the panel meter control block
// Assumes: shortened tick of 4 cycles, point select stepped through all three positions by the display test
// Notes: measured counts are allowed one count of quantisation
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module panel_meter_tb import meter_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	logic aclk, aresetn, cmp_in, freeze_wire, blank_wire, check_n;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, done_line_oe, over_line_oe;
	logic sw_input, sw_ref, ref_neg, sw_zero, sign_bar, sign_vert, irq;
	logic hold_req, blank_req, oe_q, wire_q, done_lo, over_lo;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] dp_sel_n, dp;
	logic [22:0] seg;
	logic signed [15:0] vin;
	reading_s reading;
	int n_mismatch, checks, per_c, last_per, int_c, last_int, n_fall;

	panel_meter #(.TICK_CYCLES(TK)) i_panel_meter (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.cmp_in(cmp_in), .freeze_line_in(freeze_wire),
		.done_line_o(done_lo),
		.done_line_oe(done_line_oe), .blank_line_in(blank_wire),
		.over_line_o(over_lo), .over_line_oe(over_line_oe),
		.check_n(check_n),
		.dp_sel_n(dp_sel_n), .sw_input(sw_input), .sw_ref(sw_ref),
		.ref_neg(ref_neg), .sw_zero(sw_zero), .seg(seg),
		.sign_bar(sign_bar), .sign_vert(sign_vert), .dp(dp),
		.reading(reading), .irq(irq));

	meter_far_side i_meter_far_side (.aclk(aclk), .sw_input(sw_input),
		.sw_ref(sw_ref), .ref_neg(ref_neg), .sw_zero(sw_zero), .vin(vin),
		.done_line_oe(done_line_oe), .over_line_oe(over_line_oe),
		.hold_req(hold_req), .blank_req(blank_req), .cmp_in(cmp_in),
		.freeze_wire(freeze_wire), .blank_wire(blank_wire));

	// clock of 10 ns
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// spacing of conversion starts, integration width, done wire falls
	always @(posedge aclk) begin
		per_c++;
		if (sw_input && !oe_q) begin
			last_per = per_c;
			per_c = 0;
		end
		if (sw_input)
			int_c++;
		else if (int_c != 0) begin
			last_int = int_c;
			int_c = 0;
		end
		if (wire_q && !freeze_wire)
			n_fall++;
		oe_q = sw_input;
		wire_q = freeze_wire;
	end

	function automatic logic near(reading_s r, int m);
		int c;
		c = r.half * 1000 + r.d2 * 100 + r.d1 * 10 + r.d0;
		return (c - m <= 1) && (m - c <= 1);
	endfunction

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_t, w_t;
		aw_t = 1'b0;
		w_t = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_t && w_t)) begin
			@(posedge aclk);
			if (!aw_t && s_axi_awready === 1'b1) begin
				aw_t = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_t && s_axi_wready === 1'b1) begin
				w_t = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// wait for a rise of the done drive, then let the display settle
	task automatic wait_done;
		logic p;
		p = 1'b1;
		do begin
			p = done_line_oe;
			@(posedge aclk);
		end while (!(p === 1'b0 && done_line_oe === 1'b1));
		repeat (8) @(posedge aclk);
	endtask

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(REG_CTRL, d, r);
		`CHK(d[1:0], CTRL_RST)
		axi_rd(REG_MASK, d, r);
		`CHK(d[1:0], MASK_RST)
		axi_rd(8'h10, d, r);
		`CHK({r, d}, {RESP_SLVERR, 32'h0})
		axi_wr(8'h10, 32'h3, r);
		`CHK(r, RESP_SLVERR)
		$display("test regs done");
	endtask

	task automatic t_conv(input int v);
		vin <= 16'(v);
		wait_done();
		`CHK(near(reading, v), 1'b1)
		`CHK({reading.neg, sign_bar, sign_vert}, 3'b011)
		`CHK(over_line_oe, 1'b0)
		`CHK(n_fall, 1)
		`CHK(dp, ~dp_sel_n)
		$display("test conv done");
	endtask

	task automatic t_phase;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(REG_RESULT, d, r);
		`CHK(d[21:16], 6'h01)
		do @(posedge aclk); while (sw_input !== 1'b1);
		axi_rd(REG_RESULT, d, r);
		`CHK(d[21:16], 6'h02)
		$display("test phase done");
	endtask

	task automatic t_disp;
		logic [1:0] r;
		check_n <= 1'b0;
		repeat (6) @(posedge aclk);
		`CHK({seg, sign_bar, sign_vert}, {SEG_ALL, 2'b11})
		blank_req <= 1'b1;
		repeat (6) @(posedge aclk);
		`CHK({seg, sign_bar, sign_vert, dp}, 28'h0)
		check_n <= 1'b1;
		blank_req <= 1'b0;
		axi_wr(REG_CTRL, 32'h2, r);
		repeat (2) @(posedge aclk);
		`CHK({seg, sign_bar, dp}, 27'h0)
		axi_wr(REG_CTRL, 32'h0, r);
		for (int i = 0; i < 3; i++) begin
			dp_sel_n <= ~(3'b001 << i);
			repeat (6) @(posedge aclk);
			`CHK(dp, 3'b001 << i)
		end
		$display("test display done");
	endtask

	task automatic t_irq;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(REG_STATUS, d, r);
		`CHK({d[1:0], irq}, 3'b010)
		axi_wr(REG_MASK, 32'h1, r);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b1)
		axi_wr(REG_STATUS, 32'h1, r);
		repeat (2) @(posedge aclk);
		axi_rd(REG_STATUS, d, r);
		`CHK({d[0], irq}, 2'b00)
		$display("test irq done");
	endtask

	task automatic t_neg;
		wait_done();
		`CHK(near(reading, 456), 1'b1)
		`CHK({reading.neg, sign_bar, sign_vert}, 3'b110)
		`CHK(last_per, CONV_TICKS * TK)
		`CHK(last_int, INT_TICKS * TK)
		$display("test negative done");
	endtask

	task automatic t_freeze;
		int f;
		f = n_fall;
		hold_req <= 1'b1;
		vin <= 16'sd2500;
		wait_done();
		`CHK(near(reading, 456), 1'b1)
		`CHK({reading.neg, sign_vert}, 2'b10)
		`CHK(over_line_oe, 1'b1)
		// the hold itself pulls the wire once; the done pulse adds no fall
		`CHK(n_fall, f + 1)
		hold_req <= 1'b0;
		$display("test freeze done");
	endtask

	task automatic t_over;
		logic [31:0] d;
		logic [1:0] r;
		wait_done();
		`CHK(reading.over, 1'b1)
		`CHK({seg, sign_bar, sign_vert}, {SEG_NONE, 2'b11})
		`CHK(dp, ~dp_sel_n)
		`CHK(blank_wire, 1'b0)
		`CHK({done_lo, over_lo}, 2'b00)
		axi_rd(REG_STATUS, d, r);
		`CHK({d[1:0], irq}, 3'b111)
		$display("test overrange done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog well past four conversions
	initial begin
		repeat (90000) @(posedge aclk);
		n_mismatch++;
		test_done();
	end

	// main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, hold_req, blank_req} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		check_n = 1'b1;
		dp_sel_n = 3'b110;
		vin = 16'sd0;
		{oe_q, wire_q} = 2'b11;
		{per_c, int_c, last_per, last_int, n_fall} = 160'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_regs();
		t_conv(123);
		vin <= -16'sd456;
		t_phase();
		t_disp();
		t_irq();
		t_neg();
		t_freeze();
		t_over();
		test_done();
	end
endmodule

`default_nettype wire
